// ==== dv/e1_li_checker.sv ====
module e1_li_checker
  import e1_li_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       reset_n,
  // control port
  input wire logic [7:0] host_addr,
  input wire logic       host_wr,
  input wire logic       host_rd,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  // receive clocking
  input wire logic       master_clock_in,
  input wire logic       receive_clock_out,
  input wire logic       receive_carrier_loss,
  // transmit line and driver setup
  input wire logic       transmit_line_pos_o,
  input wire logic       transmit_line_pos_oe,
  input wire logic       transmit_line_neg_o,
  input wire logic       transmit_line_neg_oe,
  input wire build_out_t build_out_cfg,
  input wire logic       build_out_valid
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] ctrl_q;
  logic [1:0] up_q;
  logic       ready;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // shadow of the control register, so outputs are tied to what the host wrote
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= LINE_IF_CTRL_RST;
    end else if (host_wr && host_addr == LINE_IF_CTRL_ADDR) begin
      ctrl_q <= host_wdata;
    end
  end

  // the design keeps its own reset copy two edges longer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      up_q <= 2'h0;
    end else if (up_q != 2'h3) begin
      up_q <= up_q + 2'h1;
    end
  end
  assign ready = (up_q == 2'h3);

  chk_pd_tristate: assert property (ready && $stable(ctrl_q) |->
    transmit_line_pos_oe == !ctrl_q[0] && transmit_line_neg_oe == !ctrl_q[0]) else $error("tx enable wrong");
  chk_pd_lines_low: assert property (ready && ctrl_q[0] && $past(ctrl_q[0]) |->
    !transmit_line_pos_o && !transmit_line_neg_o) else $error("tx marks in power down");
  chk_build_out_sel: assert property (ready && $stable(ctrl_q) |->
    build_out_cfg == ctrl_q[7:5]) else $error("build out code wrong");
  chk_build_out_valid: assert property (ready && $stable(ctrl_q) |->
    build_out_valid == (ctrl_q[7:5] <= 3'h5)) else $error("build out valid wrong");
  chk_ctrl_readback: assert property (ready && host_rd && host_addr == LINE_IF_CTRL_ADDR |=>
    host_rdata == $past(ctrl_q)) else $error("control read back wrong");
  chk_info_spare: assert property (ready && host_rd && host_addr == RX_INFO_ADDR |=>
    (host_rdata & 8'hDF) == 8'h00) else $error("info spare bits set");
  chk_rdata_holds: assert property (ready && !host_rd |=> $stable(host_rdata))
    else $error("read data moved");
  chk_rclk_on_loss: assert property (ready && receive_carrier_loss && $past(receive_carrier_loss) |->
    receive_clock_out == $past(master_clock_in)) else $error("rx clock not master");
endmodule : e1_li_checker

bind e1_line_interface_jitter_ctl e1_li_checker i_chk (.sys_clk, .reset_n, .host_addr, .host_wr, .host_rd,
  .host_wdata, .host_rdata, .master_clock_in, .receive_clock_out, .receive_carrier_loss, .transmit_line_pos_o,
  .transmit_line_pos_oe, .transmit_line_neg_o, .transmit_line_neg_oe, .build_out_cfg, .build_out_valid);

// ==== dv/e1_line_interface_jitter_ctl_bench.sv ====
module e1_line_interface_jitter_ctl_bench
  import e1_li_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic       sys_clk, reset_n, host_wr, host_rd, master_clock_in, pll_x16_tick;
  logic [7:0] host_addr, host_wdata, host_rdata;
  logic       transmit_clock_in, transmit_data_in, receive_line_pos, receive_line_neg;
  logic       receive_clock_out, receive_data_out, receive_carrier_loss, build_out_valid, receive_gain_limit;
  logic       transmit_line_pos_o, transmit_line_pos_oe, transmit_line_neg_o, transmit_line_neg_oe;
  logic       line_run, sent_bit, late_in_bit, rx_check, first_pos, duty_win;
  logic [4:0] bit_ticks;
  logic [3:0] mc_cnt;
  build_out_t build_out_cfg;
  int         err_count, total_checks, cyc, hi_cnt;

  e1_line_interface_jitter_ctl i_dut (.sys_clk, .reset_n, .host_addr, .host_wr, .host_rd, .host_wdata,
    .host_rdata, .master_clock_in, .pll_x16_tick, .transmit_clock_in, .receive_line_pos, .receive_line_neg,
    .receive_clock_out, .receive_data_out, .receive_carrier_loss, .transmit_data_in, .transmit_line_pos_o,
    .transmit_line_pos_oe, .transmit_line_neg_o, .transmit_line_neg_oe, .build_out_cfg, .build_out_valid,
    .receive_gain_limit);

  e1_line_model i_line (.sys_clk, .pll_x16_tick, .line_run, .bit_ticks, .receive_line_pos, .receive_line_neg,
    .sent_bit, .late_in_bit);

  always #25 sys_clk = ~sys_clk;

  // tick every other cycle, master clock period 32 cycles: 16 ticks per master period
  always @(posedge sys_clk) begin
    #5;
    pll_x16_tick = ~pll_x16_tick;
    mc_cnt = mc_cnt + 4'h1;
    if (mc_cnt == 4'h0) begin
      master_clock_in = ~master_clock_in;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    if (err_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask : cyc_wait

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    cyc_wait(1);
    host_wr = 1'b0;
    // idle edge so a following access never lowers and raises a strobe at once
    cyc_wait(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host_addr = a;
    host_rd = 1'b1;
    cyc_wait(1);
    host_rd = 1'b0;
    chk(host_rdata, exp);
    cyc_wait(1);
  endtask : rd

  // one transmit bit, then a gap of varying length so the clock is bursty
  task automatic tx_bit(input logic d, input int gap);
    transmit_data_in = d;
    transmit_clock_in = 1'b1;
    cyc_wait(2);
    transmit_clock_in = 1'b0;
    cyc_wait(gap);
  endtask : tx_bit

  always @(posedge sys_clk) begin
    if (rx_check && late_in_bit) begin
      chk(8'(receive_data_out), 8'(sent_bit));
    end
  end

  // high cycles of the receive clock inside the duty window
  always @(posedge sys_clk) begin
    if (duty_win && receive_clock_out) begin
      hi_cnt++;
    end
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      $display("BAD %0t run did not finish", $time);
      close_out();
    end
  end

  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    host_addr = 8'h00;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
    master_clock_in = 1'b0;
    pll_x16_tick = 1'b0;
    mc_cnt = 4'h0;
    transmit_clock_in = 1'b0;
    transmit_data_in = 1'b0;
    line_run = 1'b0;
    bit_ticks = 5'h10;
    rx_check = 1'b0;
    duty_win = 1'b0;
    repeat (8) @(posedge sys_clk);
    #5;
    reset_n = 1'b1;
    cyc_wait(3);
    rd(LINE_IF_CTRL_ADDR, LINE_IF_CTRL_RST);
    rd(RX_INFO_ADDR, 8'h00);
    chk(8'(receive_carrier_loss), 8'h01);
    for (int i = 0; i < 8; i++) begin
      wr(LINE_IF_CTRL_ADDR, 8'((i << 5) | 8'h10));
      rd(LINE_IF_CTRL_ADDR, 8'((i << 5) | 8'h10));
      chk(8'(build_out_cfg), 8'(i));
      chk(8'(build_out_valid), 8'(i <= 5));
      chk(8'(receive_gain_limit), 8'h01);
    end
    wr(LINE_IF_CTRL_ADDR, 8'h01);
    cyc_wait(1);
    chk({4'h0, transmit_line_pos_oe, transmit_line_neg_oe, transmit_line_pos_o, transmit_line_neg_o}, 8'h00);
    wr(LINE_IF_CTRL_ADDR, 8'h00);
    wr(RX_INFO_ADDR, 8'hFF);
    rd(8'h20, 8'h00);
    rd(LINE_IF_CTRL_ADDR, 8'h00);
    chk({6'h0, transmit_line_pos_oe, transmit_line_neg_oe}, 8'h03);
    tx_bit(1'b1, 3);
    first_pos = transmit_line_pos_o;
    chk(8'(transmit_line_pos_o ^ transmit_line_neg_o), 8'h01);
    tx_bit(1'b1, 9);
    chk({6'h0, transmit_line_pos_o, transmit_line_neg_o}, {6'h0, ~first_pos, first_pos});
    // power down while a mark is still showing on the line
    wr(LINE_IF_CTRL_ADDR, 8'h01);
    chk({4'h0, transmit_line_pos_oe, transmit_line_neg_oe, transmit_line_pos_o, transmit_line_neg_o}, 8'h00);
    wr(LINE_IF_CTRL_ADDR, 8'h00);
    tx_bit(1'b0, 5);
    chk({6'h0, transmit_line_pos_o, transmit_line_neg_o}, 8'h00);
    wr(LINE_IF_CTRL_ADDR, 8'h02);
    line_run = 1'b1;
    cyc_wait(160);
    rx_check = 1'b1;
    cyc_wait(1280);
    rx_check = 1'b0;
    chk(8'(receive_carrier_loss), 8'h00);
    // recovered clock is high for the short phases only: ten bits of 32 cycles
    duty_win = 1'b1;
    cyc_wait(320);
    duty_win = 1'b0;
    chk(8'(hi_cnt), 8'(20 * SHORT_HIGH_END));
    bit_ticks = 5'h0F;
    cyc_wait(3000);
    rd(RX_INFO_ADDR, 8'h00);
    line_run = 1'b0;
    cyc_wait(8400);
    chk(8'(receive_carrier_loss), 8'h01);
    wr(LINE_IF_CTRL_ADDR, 8'h04);
    line_run = 1'b1;
    cyc_wait(12000);
    // disable first so the sticky flag is read while no new trip can land
    wr(LINE_IF_CTRL_ADDR, 8'h06);
    rd(RX_INFO_ADDR, 8'h20);
    cyc_wait(600);
    rd(RX_INFO_ADDR, 8'h00);
    close_out();
  end
endmodule : e1_line_interface_jitter_ctl_bench

// ==== dv/e1_line_model.sv ====
module e1_line_model
  import e1_li_pkg::*;
(
  // clock and oversample tick
  input  wire logic       sys_clk,
  input  wire logic       pll_x16_tick,
  // line control
  input  wire logic       line_run,
  input  wire logic [4:0] bit_ticks,
  // receive pair toward the device
  output logic            receive_line_pos,
  output logic            receive_line_neg,
  // bit on the line, strobe late in the bit
  output logic            sent_bit,
  output logic            late_in_bit
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] pattern_q;
  logic [4:0]  phase_q;
  logic        pos_next_q;

  initial begin
    pattern_q = 16'hF3A5;
    phase_q = 5'h0;
    pos_next_q = 1'b1;
    sent_bit = 1'b0;
    late_in_bit = 1'b0;
    receive_line_pos = 1'b0;
    receive_line_neg = 1'b0;
  end

  // one bit lasts bit_ticks oversample ticks; 16 nominal, 15 to fill the buffer until its read divides by 15
  always @(posedge sys_clk) begin
    if (pll_x16_tick) begin
      #5;
      phase_q = (phase_q + 5'h1 >= bit_ticks) ? 5'h0 : phase_q + 5'h1;
      if (phase_q == 5'h0) begin
        pattern_q = {pattern_q[14:0], pattern_q[15]};
        sent_bit = pattern_q[15] && line_run;
        if (sent_bit) begin
          pos_next_q = ~pos_next_q;
        end
      end
      // marks are half a bit wide and return to zero, so no tail spills past the sample point
      receive_line_pos = sent_bit && pos_next_q && phase_q < 5'h8;
      receive_line_neg = sent_bit && !pos_next_q && phase_q < 5'h8;
      late_in_bit = line_run && phase_q == 5'hD;
    end
  end
endmodule : e1_line_model

// ==== logic/e1_line_interface_jitter_ctl.sv ====
// Behaviour
// - side bit places attenuator: rx or tx
// - depth bit selects 128 or 32 bits
// - disable bit removes attenuator from path
// - power down tristates both transmit outputs
// - top three bits select build out
// - six build out configs, 75/120 ohm
// - x16 oversampling recovers clock and data
// - carrier loss switches receive clock to master
// - attenuator on receive restores 50% duty
// - smoothed clock reads the attenuator buffer
// - gapped transmit clock accepted on tx side
// - divide by 15/17 near buffer limits
// - limit trip flag set on 15/17
module e1_line_interface_jitter_ctl
  import e1_li_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // control port
  input  wire logic [7:0] host_addr,
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  input  wire logic [7:0] host_wdata,
  output logic [7:0]      host_rdata,
  // clocks
  input  wire logic       master_clock_in,
  input  wire logic       pll_x16_tick,
  input  wire logic       transmit_clock_in,
  // receive line
  input  wire logic       receive_line_pos,
  input  wire logic       receive_line_neg,
  // receive framer side
  output logic            receive_clock_out,
  output logic            receive_data_out,
  output logic            receive_carrier_loss,
  // transmit framer side
  input  wire logic       transmit_data_in,
  // transmit line
  output logic            transmit_line_pos_o,
  output logic            transmit_line_pos_oe,
  output logic            transmit_line_neg_o,
  output logic            transmit_line_neg_oe,
  // line driver and receiver configuration
  output build_out_t      build_out_cfg,
  output logic            build_out_valid,
  output logic            receive_gain_limit
);

  logic           rst_meta_q;
  logic           rst_n_s;
  line_ctrl_t     ctrl_q;
  logic           trip_flag_q;
  logic           trip_pulse;
  logic           atten_enable;
  logic           atten_on_tx;
  logic           pulse_now;
  logic           pulse_prev_q;
  logic           pulse_seen_q;
  logic [3:0]     os_phase_q;
  logic [7:0]     zero_run_q;
  carrier_state_t carrier_q;
  bit_stream_t    rx_rec_q;
  logic           rec_clk_q;
  logic           transmit_clock_prev_q;
  bit_stream_t    tx_in;
  bit_stream_t    ja_in;
  bit_stream_t    ja_out;
  bit_stream_t    tx_bits;
  bit_stream_t    rx_bits;
  logic           smooth_clk;
  logic           ami_mark_neg_q;
  logic           rd_info;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_s    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_s    <= rst_meta_q;
    end
  end

  // control port
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ctrl_q <= line_ctrl_t'(LINE_IF_CTRL_RST);
    end else if (host_wr && host_addr == LINE_IF_CTRL_ADDR) begin
      ctrl_q <= line_ctrl_t'(host_wdata);
    end
  end

  assign rd_info = host_rd && (host_addr == RX_INFO_ADDR);

  // trip flag is latched and cleared on read; a new trip beats the clear
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      trip_flag_q <= 1'b0;
    end else if (trip_pulse) begin
      trip_flag_q <= 1'b1;
    end else if (rd_info) begin
      trip_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      host_rdata <= 8'h00;
    end else if (host_rd) begin
      if (host_addr == LINE_IF_CTRL_ADDR) begin
        host_rdata <= ctrl_q;
      end else if (host_addr == RX_INFO_ADDR) begin
        host_rdata <= 8'(trip_flag_q) << RI_LIMIT_TRIP;
      end else begin
        host_rdata <= 8'h00;
      end
    end
  end

  // line driver waveform selection
  always_comb begin
    build_out_cfg   = build_out_t'(ctrl_q.build_out_sel);
    build_out_valid = (ctrl_q.build_out_sel <= BO_120_HIGH_RL);
  end

  assign receive_gain_limit = ctrl_q.receive_gain_limit;
  assign atten_enable       = !ctrl_q.attenuator_disable;
  assign atten_on_tx        = ctrl_q.attenuator_side_select;

  // oversampled recovery: each tick is one sixteenth of a bit
  assign pulse_now = receive_line_pos || receive_line_neg;

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pulse_prev_q <= 1'b0;
      pulse_seen_q <= 1'b0;
      os_phase_q   <= 4'h0;
      rx_rec_q     <= '0;
      rec_clk_q    <= 1'b0;
    end else begin
      rx_rec_q.strobe <= 1'b0;
      if (pll_x16_tick) begin
        pulse_prev_q <= pulse_now;
        // a fresh mark realigns the bit window
        if (pulse_now && !pulse_prev_q) begin
          os_phase_q <= 4'h0;
        end else begin
          os_phase_q <= (os_phase_q == OS_LAST_PHASE) ? 4'h0 : os_phase_q + 4'h1;
        end
        if (os_phase_q == SAMPLE_PHASE) begin
          rx_rec_q.strobe <= 1'b1;
          rx_rec_q.data   <= pulse_seen_q || pulse_now;
          pulse_seen_q    <= 1'b0;
        end else if (pulse_now) begin
          pulse_seen_q <= 1'b1;
        end
        // recovered clock high phase is a little short of half
        rec_clk_q <= (os_phase_q < SHORT_HIGH_END);
      end
    end
  end

  // carrier loss after a long run of spaces
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      zero_run_q <= 8'h00;
      carrier_q  <= CARRIER_LOST;
    end else if (rx_rec_q.strobe) begin
      if (rx_rec_q.data) begin
        zero_run_q <= 8'h00;
      end else if (zero_run_q != LOS_ZERO_LIMIT) begin
        zero_run_q <= zero_run_q + 8'h01;
      end
      case (carrier_q)
        CARRIER_LOST: begin
          if (rx_rec_q.data) begin
            carrier_q <= CARRIER_SEEN;
          end
        end
        CARRIER_SEEN: begin
          carrier_q <= rx_rec_q.data ? CARRIER_OK : CARRIER_LOST;
        end
        CARRIER_OK: begin
          if (zero_run_q == LOS_ZERO_LIMIT - 8'h01 && !rx_rec_q.data) begin
            carrier_q <= CARRIER_LOST;
          end
        end
        default: begin
          carrier_q <= CARRIER_LOST;
        end
      endcase
    end
  end

  assign receive_carrier_loss = (carrier_q == CARRIER_LOST);

  // transmit clock may be gapped: each rising edge carries one bit
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      transmit_clock_prev_q <= 1'b0;
    end else begin
      transmit_clock_prev_q <= transmit_clock_in;
    end
  end

  assign tx_in.strobe = transmit_clock_in && !transmit_clock_prev_q;
  assign tx_in.data   = transmit_data_in;

  // one attenuator, steered to either path
  assign ja_in = atten_on_tx ? tx_in : rx_rec_q;

  jitter_atten u_jitter_atten (
    .sys_clk       (sys_clk),
    .rst_n         (rst_n_s),
    .pll_x16_tick  (pll_x16_tick),
    .atten_enable  (atten_enable),
    .depth_shallow (ctrl_q.attenuator_depth_select),
    .in_bits       (ja_in),
    .out_bits      (ja_out),
    .smooth_clk    (smooth_clk),
    .limit_trip    (trip_pulse)
  );

  assign tx_bits = atten_on_tx ? ja_out : tx_in;
  assign rx_bits = atten_on_tx ? rx_rec_q : ja_out;

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      receive_data_out  <= 1'b0;
      receive_clock_out <= 1'b0;
    end else begin
      if (rx_bits.strobe) begin
        receive_data_out <= rx_bits.data;
      end
      if (receive_carrier_loss) begin
        receive_clock_out <= master_clock_in;
      end else if (!atten_on_tx && atten_enable) begin
        receive_clock_out <= smooth_clk;
      end else begin
        receive_clock_out <= rec_clk_q;
      end
    end
  end

  // alternate mark inversion toward the line driver
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      transmit_line_pos_o <= 1'b0;
      transmit_line_neg_o <= 1'b0;
      ami_mark_neg_q      <= 1'b0;
    end else if (ctrl_q.transmitter_power_down) begin
      transmit_line_pos_o <= 1'b0;
      transmit_line_neg_o <= 1'b0;
    end else if (tx_bits.strobe) begin
      transmit_line_pos_o <= tx_bits.data && !ami_mark_neg_q;
      transmit_line_neg_o <= tx_bits.data && ami_mark_neg_q;
      if (tx_bits.data) begin
        ami_mark_neg_q <= !ami_mark_neg_q;
      end
    end
  end

  assign transmit_line_pos_oe = !ctrl_q.transmitter_power_down;
  assign transmit_line_neg_oe = !ctrl_q.transmitter_power_down;

endmodule : e1_line_interface_jitter_ctl

// ==== logic/jitter_atten.sv ====
module jitter_atten
  import e1_li_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // control
  input  wire logic        pll_x16_tick,
  input  wire logic        atten_enable,
  input  wire logic        depth_shallow,
  // stream in and out
  input  wire bit_stream_t in_bits,
  output bit_stream_t      out_bits,
  output logic             smooth_clk,
  output logic             limit_trip
);

  logic [FIFO_DEPTH_DEEP-1:0] mem_q;
  logic [6:0]                 wr_ptr_q;
  logic [6:0]                 rd_ptr_q;
  logic [7:0]                 fill_q;
  logic [7:0]                 depth;
  logic [7:0]                 margin;
  logic [4:0]                 div_q;
  logic [4:0]                 div_d;
  logic [4:0]                 phase_q;
  logic                       primed_q;
  logic                       period_end;
  logic                       do_read;
  logic                       do_write;
  bit_stream_t                fifo_out_q;

  assign depth      = depth_shallow ? DEPTH_SHALLOW : DEPTH_DEEP;
  assign margin     = depth_shallow ? MARGIN_SHALLOW : MARGIN_DEEP;
  assign period_end = pll_x16_tick && (phase_q == div_q - 5'h01);
  assign do_read    = atten_enable && period_end && primed_q && (fill_q != 8'h00);
  // a full buffer drops the new bit rather than corrupting the oldest one
  assign do_write   = atten_enable && in_bits.strobe && (fill_q != depth);

  // stretch or shrink the read period when the fill nears either edge
  always_comb begin
    div_d = DIV_NOMINAL;
    if (fill_q >= depth - margin) begin
      div_d = DIV_FAST;
    end else if (primed_q && fill_q <= margin) begin
      div_d = DIV_SLOW;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 5'h00;
      div_q   <= DIV_NOMINAL;
    end else if (!atten_enable) begin
      phase_q <= 5'h00;
      div_q   <= DIV_NOMINAL;
    end else if (period_end) begin
      phase_q <= 5'h00;
      div_q   <= div_d;
    end else if (pll_x16_tick) begin
      phase_q <= phase_q + 5'h01;
    end
  end

  // flag each period run at 15 or 17, never while bypassed
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      limit_trip <= 1'b0;
    end else begin
      limit_trip <= atten_enable && period_end && (div_d != DIV_NOMINAL);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= 7'h00;
      rd_ptr_q <= 7'h00;
      fill_q   <= 8'h00;
      primed_q <= 1'b0;
    end else if (!atten_enable) begin
      wr_ptr_q <= 7'h00;
      rd_ptr_q <= 7'h00;
      fill_q   <= 8'h00;
      primed_q <= 1'b0;
    end else begin
      if (do_write) begin
        wr_ptr_q <= (8'(wr_ptr_q) == depth - 8'h01) ? 7'h00 : wr_ptr_q + 7'h01;
      end
      if (do_read) begin
        rd_ptr_q <= (8'(rd_ptr_q) == depth - 8'h01) ? 7'h00 : rd_ptr_q + 7'h01;
      end
      fill_q <= fill_q + 8'(do_write) - 8'(do_read);
      // reading starts half full so the buffer absorbs jitter both ways
      if (fill_q >= (depth >> 1)) begin
        primed_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (do_write) begin
      mem_q[wr_ptr_q] <= in_bits.data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_out_q <= '0;
      smooth_clk <= 1'b0;
    end else begin
      fifo_out_q.strobe <= do_read;
      if (do_read) begin
        fifo_out_q.data <= mem_q[rd_ptr_q];
      end
      smooth_clk <= atten_enable && ({phase_q, 1'b0} < div_q);
    end
  end

  // disabled: the stream passes straight through with no buffer delay
  assign out_bits = atten_enable ? fifo_out_q : in_bits;

endmodule : jitter_atten

// ==== pkg/e1_li_pkg.sv ====
package e1_li_pkg;

  // register map of the control port
  localparam logic [7:0] LINE_IF_CTRL_ADDR = 8'h18;
  localparam logic [7:0] RX_INFO_ADDR      = 8'h1E;
  localparam logic [7:0] LINE_IF_CTRL_RST  = 8'h00;

  // line interface control fields
  localparam int LIC_BUILD_OUT_LSB = 5;
  localparam int LIC_GAIN_LIMIT    = 4;
  localparam int LIC_SIDE_SELECT   = 3;
  localparam int LIC_DEPTH_SELECT  = 2;
  localparam int LIC_DISABLE       = 1;
  localparam int LIC_POWER_DOWN    = 0;

  // receive information fields
  localparam int RI_LIMIT_TRIP = 5;

  // oversampling clock recovery
  localparam logic [3:0] OS_LAST_PHASE  = 4'hF;
  localparam logic [3:0] SAMPLE_PHASE   = 4'h8;
  localparam logic [3:0] SHORT_HIGH_END = 4'h7;
  localparam logic [7:0] LOS_ZERO_LIMIT = 8'hFF;

  // jitter attenuator
  localparam int         FIFO_DEPTH_DEEP    = 128;
  localparam int         FIFO_DEPTH_SHALLOW = 32;
  localparam int         JIT_DEEP_UIPP      = 120;
  localparam int         JIT_SHALLOW_UIPP   = 28;
  localparam logic [7:0] DEPTH_DEEP         = 8'(FIFO_DEPTH_DEEP);
  localparam logic [7:0] DEPTH_SHALLOW      = 8'(FIFO_DEPTH_SHALLOW);
  localparam logic [7:0] MARGIN_DEEP        = 8'((FIFO_DEPTH_DEEP - JIT_DEEP_UIPP) / 2);
  localparam logic [7:0] MARGIN_SHALLOW     = 8'((FIFO_DEPTH_SHALLOW - JIT_SHALLOW_UIPP) / 2);
  localparam logic [4:0] DIV_NOMINAL        = 5'h10;
  localparam logic [4:0] DIV_FAST           = 5'h0F;
  localparam logic [4:0] DIV_SLOW           = 5'h11;

  typedef enum logic [2:0] {
    BO_75_NORMAL  = 3'h0,
    BO_120_NORMAL = 3'h1,
    BO_75_PROT    = 3'h2,
    BO_120_PROT   = 3'h3,
    BO_75_HIGH_RL = 3'h4,
    BO_120_HIGH_RL = 3'h5
  } build_out_t;

  typedef enum logic [1:0] {
    CARRIER_LOST = 2'b00,
    CARRIER_SEEN = 2'b01,
    CARRIER_OK   = 2'b11
  } carrier_state_t;

  typedef struct packed {
    logic [2:0] build_out_sel;
    logic       receive_gain_limit;
    logic       attenuator_side_select;
    logic       attenuator_depth_select;
    logic       attenuator_disable;
    logic       transmitter_power_down;
  } line_ctrl_t;

  typedef struct packed {
    logic strobe;
    logic data;
  } bit_stream_t;

endpackage : e1_li_pkg
